// ===== verilog/rtc_sram_ctrl.sv
// Byte-wide clock SRAM: power-fail deselect, write protection and clock byte freeze.
// Assumes host strobes and supply comparator levels are synchronous to clk.
// Functional notes
// (RL1) Supply inside the power-fail window deselects the part and blocks every write.
// (RL2) While deselected the data pins float and strobes, address and data are ignored.
// (RL3) A write cut by power failure is dropped, so no other byte can be touched.
// (RL4) Below the lower threshold the part is write protected after a slow supply fall.
// (RL5) After a fast fall protection may come up to 50 us late; here it follows one clock later.
// (RL6) Below switchover the part runs from backup and the time counters keep running.
// (RL7) At power-up deselect holds for the recovery time after the supply passes threshold.
// (RL8) The host is advised to freeze updates before reading the clock bytes.
// (RL9) A one in the freeze bit stops the counter-to-byte copy while it stays one.
// (RL10) Freezing holds only the readable bytes; the counters keep time.
// (RL11) While frozen the bytes show the time current when the freeze took effect.
// (RL12) Each copy updates all clock bytes in one step.
// (RL13) A freeze set during a copy lets that copy complete first.
// (RL14) After the freeze bit clears the next copy comes one second later.
// (RL15) Unless halted the counters are copied into the top seven bytes once a second.
// (RL16) The time-load bit halts copies like the freeze bit does.
`timescale 1ns/1ps
module rtc_sram_ctrl #(
    parameter int unsigned SEC_CYCLES = rtc_sram_pkg::SEC_CYCLES,  // Cycles per second tick
    parameter int unsigned REC_CYCLES = rtc_sram_pkg::REC_CYCLES   // Power-up deselect hold
) (
    input  wire logic                              clk,              // 40 MHz clock
    input  wire logic                              reset_n,          // Synchronous reset
    input  wire logic                              chipEnable_n,     // Chip select, low active
    input  wire logic                              outEnable_n,      // Output gate, low active
    input  wire logic                              writeEnable_n,    // Write strobe, low active
    input  wire logic [rtc_sram_pkg::ADDR_W-1:0]   addr,             // Byte address
    input  wire logic [rtc_sram_pkg::DATA_W-1:0]   dqIn,             // Data pins, in
    output logic      [rtc_sram_pkg::DATA_W-1:0]   dqOut,            // Data pins, out
    output logic                                   dqOe,             // Data pins driven
    input  wire logic                              aboveFailThreshold, // Supply above power_fail_threshold
    input  wire logic                              belowSwitchover,  // Supply below battery_switchover_threshold
    output logic                                   onBattery,        // Running from backup source
    output logic                                   deselected        // Power-fail deselect active
);
    import rtc_sram_pkg::*;

    if (SEC_CYCLES < 2 || REC_CYCLES < 1) begin : g_bad_param
        $error("rtc_sram_ctrl: SEC_CYCLES must be >= 2 and REC_CYCLES >= 1");
    end

    function automatic logic [7:0] bcdInc(input logic [7:0] v);
        bcdInc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic [7:0] lastDate(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        if (mon == 8'h02) begin
            lastDate = leap ? 8'h29 : 8'h28;
        end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
            lastDate = 8'h30;
        end else begin
            lastDate = 8'h31;
        end
    endfunction

    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [7:0]        cnt_ff [1:7];
    logic [7:0]        clkReg_ff [1:7];
    logic [7:0]        ctrl_ff;
    logic [31:0]       divCnt_ff;
    logic [31:0]       recCnt_ff;
    logic              deselect_ff;
    logic              wrActive_ff;
    logic [ADDR_W-1:0] wrAddr_ff;
    logic [DATA_W-1:0] wrData_ff;
    logic [DATA_W-1:0] dqOut_ff;
    logic              onBattery_ff;

    // Bus decode
    wire        selected   = !deselect_ff && !chipEnable_n;
    wire        wrStrobe   = selected && !writeEnable_n;
    wire        wrCommit   = wrActive_ff && !wrStrobe && !deselect_ff;
    wire        wrIsClock  = (wrAddr_ff >= CLOCK_BASE_ADDR);
    wire [2:0]  wrIdx      = wrAddr_ff[2:0];
    wire        rdIsClock  = (addr >= CLOCK_BASE_ADDR);
    wire [2:0]  rdIdx      = addr[2:0];
    wire [7:0]  rdClock    = (rdIdx == IDX_CONTROL) ? ctrl_ff : clkReg_ff[rdIdx];
    wire [7:0]  rdData     = rdIsClock ? rdClock : mem[addr];
    wire        ctrlWrite  = wrCommit && wrIsClock && (wrIdx == IDX_CONTROL);
    wire [7:0]  nxt_ctrl   = ctrlWrite ? wrData_ff : ctrl_ff;
    // (RL16) load bit halts too
    wire        halted     = ctrl_ff[CTRL_FREEZE_BIT] || ctrl_ff[CTRL_LOAD_BIT];
    wire        nxt_halted = nxt_ctrl[CTRL_FREEZE_BIT] || nxt_ctrl[CTRL_LOAD_BIT];
    wire        loadDone   = ctrl_ff[CTRL_LOAD_BIT] && !nxt_ctrl[CTRL_LOAD_BIT];
    wire        secTick    = (divCnt_ff == SEC_CYCLES - 1);
    // (RL13) copy decided on current state
    wire        doCopy     = secTick && !halted;
    wire        recDone    = (recCnt_ff >= REC_CYCLES);

    // (RL1) threshold drives deselect
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            recCnt_ff   <= 32'h0000_0000;
            deselect_ff <= 1'b1;
        end else begin
            // (RL7) recovery hold after power-up
            recCnt_ff   <= !aboveFailThreshold ? 32'h0000_0000 : (recDone ? recCnt_ff : recCnt_ff + 32'h0000_0001);
            // (RL4) protection one clock after the fall
            // (RL5) no late protection window
            deselect_ff <= !aboveFailThreshold || !(recDone || recCnt_ff == REC_CYCLES - 1);
        end
    end

    // (RL2) inputs ignored while deselected
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wrActive_ff <= 1'b0;
            wrAddr_ff   <= '0;
            wrData_ff   <= '0;
        end else begin
            wrActive_ff <= wrStrobe;
            if (wrStrobe) begin
                wrAddr_ff <= addr;
                wrData_ff <= dqIn;
            end
        end
    end

    // (RL3) aborted writes never reach memory
    always_ff @(posedge clk) begin
        if (wrCommit && !wrIsClock) begin
            mem[wrAddr_ff] <= wrData_ff;
        end
    end

    // (RL14) divider restarts when halt clears
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            divCnt_ff <= 32'h0000_0000;
        end else if ((halted && !nxt_halted) || secTick) begin
            divCnt_ff <= 32'h0000_0000;
        end else begin
            divCnt_ff <= divCnt_ff + 32'h0000_0001;
        end
    end

    // (RL6) counters advance in every supply state
    // (RL10) counters never halted
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_ff[IDX_SECONDS] <= SEC_RESET;
            cnt_ff[IDX_MINUTES] <= MIN_RESET;
            cnt_ff[IDX_HOURS]   <= HOUR_RESET;
            cnt_ff[IDX_DAY]     <= DAY_RESET;
            cnt_ff[IDX_DATE]    <= DATE_RESET;
            cnt_ff[IDX_MONTH]   <= MONTH_RESET;
            cnt_ff[IDX_YEAR]    <= YEAR_RESET;
        end else if (loadDone) begin
            for (int i = 1; i <= 7; i++) begin
                cnt_ff[i] <= clkReg_ff[i];
            end
        end else if (secTick) begin
            cnt_ff[IDX_SECONDS] <= (cnt_ff[IDX_SECONDS] >= SEC_MAX) ? SEC_RESET : bcdInc(cnt_ff[IDX_SECONDS]);
            if (cnt_ff[IDX_SECONDS] >= SEC_MAX) begin
                cnt_ff[IDX_MINUTES] <= (cnt_ff[IDX_MINUTES] >= SEC_MAX) ? MIN_RESET : bcdInc(cnt_ff[IDX_MINUTES]);
                if (cnt_ff[IDX_MINUTES] >= SEC_MAX) begin
                    cnt_ff[IDX_HOURS] <= (cnt_ff[IDX_HOURS] >= HOUR_MAX) ? HOUR_RESET : bcdInc(cnt_ff[IDX_HOURS]);
                    if (cnt_ff[IDX_HOURS] >= HOUR_MAX) begin
                        cnt_ff[IDX_DAY] <= (cnt_ff[IDX_DAY] >= DAY_MAX) ? DAY_RESET : bcdInc(cnt_ff[IDX_DAY]);
                        if (cnt_ff[IDX_DATE] >= lastDate(cnt_ff[IDX_MONTH], cnt_ff[IDX_YEAR])) begin
                            cnt_ff[IDX_DATE] <= DATE_RESET;
                            cnt_ff[IDX_MONTH] <= (cnt_ff[IDX_MONTH] >= MONTH_MAX) ? MONTH_RESET
                                                                                  : bcdInc(cnt_ff[IDX_MONTH]);
                            if (cnt_ff[IDX_MONTH] >= MONTH_MAX) begin
                                cnt_ff[IDX_YEAR] <= (cnt_ff[IDX_YEAR] >= YEAR_MAX) ? YEAR_RESET
                                                                                   : bcdInc(cnt_ff[IDX_YEAR]);
                            end
                        end else begin
                            cnt_ff[IDX_DATE] <= bcdInc(cnt_ff[IDX_DATE]);
                        end
                    end
                end
            end
        end
    end

    // (RL12) all bytes copied in one cycle
    // (RL15) once-per-second copy
    // (RL9) freeze bit blocks copy
    // (RL11) held bytes keep frozen time
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_ff <= CTRL_RESET;
            for (int i = 1; i <= 7; i++) begin
                clkReg_ff[i] <= 8'h00;
            end
        end else begin
            ctrl_ff <= nxt_ctrl;
            if (doCopy) begin
                for (int i = 1; i <= 7; i++) begin
                    clkReg_ff[i] <= cnt_ff[i];
                end
            end else if (wrCommit && wrIsClock && wrIdx != IDX_CONTROL) begin
                clkReg_ff[wrIdx] <= wrData_ff;
            end
        end
    end

    // Read data and pin drive
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dqOut_ff     <= '0;
            onBattery_ff <= 1'b0;
        end else begin
            dqOut_ff     <= rdData;
            onBattery_ff <= belowSwitchover;
        end
    end

    assign dqOut      = dqOut_ff;
    // (RL2) pins float when deselected
    assign dqOe       = selected && !outEnable_n && writeEnable_n;
    assign onBattery  = onBattery_ff;
    assign deselected = deselect_ff;

    a_deselect_float: assert property (@(posedge clk) disable iff (!reset_n) // RL2
        deselect_ff |-> !dqOe) else $error("data pins driven while deselected");

    a_fail_no_write: assert property (@(posedge clk) disable iff (!reset_n) // RL1
        !aboveFailThreshold |=> !wrCommit ##1 !wrCommit) else $error("write accepted during power fail");

    a_below_protect: assert property (@(posedge clk) disable iff (!reset_n) // RL4
        !aboveFailThreshold |=> deselected) else $error("not protected below threshold");

    a_recovery_hold: assert property (@(posedge clk) disable iff (!reset_n) // RL7
        $rose(aboveFailThreshold) |=> deselected [*8]) else $error("deselect released too early");

    a_freeze_hold: assert property (@(posedge clk) disable iff (!reset_n) // RL9
        (halted && !wrCommit) |=> $stable(clkReg_ff[IDX_SECONDS]) && $stable(clkReg_ff[IDX_YEAR]))
        else $error("clock bytes changed while frozen");

    a_copy_atomic: assert property (@(posedge clk) disable iff (!reset_n) // RL12
        doCopy |=> clkReg_ff[IDX_SECONDS] == $past(cnt_ff[IDX_SECONDS])
                   && clkReg_ff[IDX_DATE] == $past(cnt_ff[IDX_DATE])) else $error("copy not atomic");

    a_counters_run: assert property (@(posedge clk) disable iff (!reset_n) // RL10
        (secTick && halted && !loadDone) |=> cnt_ff[IDX_SECONDS] != $past(cnt_ff[IDX_SECONDS]))
        else $error("counters stopped by freeze");

    a_copy_completes: assert property (@(posedge clk) disable iff (!reset_n) // RL13
        (doCopy && ctrlWrite && nxt_halted) |=> clkReg_ff[IDX_MINUTES] == $past(cnt_ff[IDX_MINUTES]))
        else $error("copy cut short by freeze");

    a_unfreeze_delay: assert property (@(posedge clk) disable iff (!reset_n) // RL14
        (halted && !nxt_halted) |=> divCnt_ff == 32'h0000_0000) else $error("divider not restarted");

    a_battery_follow: assert property (@(posedge clk) disable iff (!reset_n) // RL6
        belowSwitchover |=> onBattery) else $error("backup source not selected");
endmodule

// ===== verilog/rtc_sram_pkg.sv
// Constants shared by the battery-backed clock SRAM control block.
// Assumes a 40 MHz system clock and byte-wide host strobes synchronous to that clock.
package rtc_sram_pkg;
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned ADDR_W          = 17;
    localparam int unsigned DATA_W          = 8;
    // Clock byte map at the top of memory
    localparam logic [16:0] CLOCK_BASE_ADDR = 17'h1_FFF8;
    localparam logic [16:0] CLOCK_CONTROL_ADDR = 17'h1_FFF8;
    localparam logic [2:0]  IDX_CONTROL     = 3'h0;
    localparam logic [2:0]  IDX_SECONDS     = 3'h1;
    localparam logic [2:0]  IDX_MINUTES     = 3'h2;
    localparam logic [2:0]  IDX_HOURS       = 3'h3;
    localparam logic [2:0]  IDX_DAY         = 3'h4;
    localparam logic [2:0]  IDX_DATE        = 3'h5;
    localparam logic [2:0]  IDX_MONTH       = 3'h6;
    localparam logic [2:0]  IDX_YEAR        = 3'h7;
    // Control byte fields
    localparam int unsigned CTRL_LOAD_BIT   = 7;
    localparam int unsigned CTRL_FREEZE_BIT = 6;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    // Time counter values after reset and maximum values before wrap (BCD)
    localparam logic [7:0]  SEC_RESET       = 8'h00;
    localparam logic [7:0]  MIN_RESET       = 8'h00;
    localparam logic [7:0]  HOUR_RESET      = 8'h00;
    localparam logic [7:0]  DAY_RESET       = 8'h01;
    localparam logic [7:0]  DATE_RESET      = 8'h01;
    localparam logic [7:0]  MONTH_RESET     = 8'h01;
    localparam logic [7:0]  YEAR_RESET      = 8'h00;
    localparam logic [7:0]  SEC_MAX         = 8'h59;
    localparam logic [7:0]  HOUR_MAX        = 8'h23;
    localparam logic [7:0]  DAY_MAX         = 8'h07;
    localparam logic [7:0]  MONTH_MAX       = 8'h12;
    localparam logic [7:0]  YEAR_MAX        = 8'h99;
    // Timing: one second, and the power-up deselect hold in ms
    localparam int unsigned SECOND_MS       = 1000;
    localparam int unsigned SEC_CYCLES      = CLK_HZ / 1000 * SECOND_MS;
    localparam int unsigned REC_HOLD_MIN_MS = 40;
    localparam int unsigned REC_HOLD_MAX_MS = 200;
    localparam int unsigned REC_CYCLES      = (CLK_HZ / 1000) * REC_HOLD_MIN_MS;
    localparam int unsigned MIN_FALL_US     = 300;
    localparam int unsigned LATE_PROTECT_US = 50;
endpackage

// ===== dv/host_model.sv
// Host processor model for the byte-wide asynchronous bus.
// Assumes the bench calls its tasks; pins change only at falling clock edges.
`timescale 1ns/1ps
module host_model (
    input  wire logic        clk,           // Bus clock
    output logic             chipEnable_n,  // Chip select
    output logic             outEnable_n,   // Output gate
    output logic             writeEnable_n, // Write strobe
    output logic [16:0]      addr,          // Byte address
    output logic [7:0]       dqIn,          // Write data
    input  wire logic [7:0]  dqOut,         // Read data
    input  wire logic        dqOe           // Device drives data
);
    logic [8:0] seenData;
    event       readSeen;

    initial begin
        chipEnable_n  = 1'b1;
        outEnable_n   = 1'b1;
        writeEnable_n = 1'b1;
        addr          = 17'h0_0000;
        dqIn          = 8'h00;
    end

    // Strobes go high; address and data show the inverse of their last value
    task automatic release_bus;
        chipEnable_n  = 1'b1;
        outEnable_n   = 1'b1;
        writeEnable_n = 1'b1;
        addr          = ~addr;
        dqIn          = ~dqIn;
    endtask

    task automatic write_begin(input logic [16:0] a, input logic [7:0] d);
        @(negedge clk);
        chipEnable_n  = 1'b0;
        writeEnable_n = 1'b0;
        addr          = a;
        dqIn          = d;
    endtask

    task automatic write_end;
        @(negedge clk);
        release_bus();
    endtask

    task automatic write_at(input logic [16:0] a, input logic [7:0] d);
        write_begin(a, d);
        write_end();
    endtask

    // Data is taken before the strobes are released
    task automatic read_at(input logic [16:0] a);
        @(negedge clk);
        chipEnable_n = 1'b0;
        outEnable_n  = 1'b0;
        addr         = a;
        @(negedge clk);
        seenData = {dqOe, dqOut};
        -> readSeen;
        release_bus();
    endtask
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the clock SRAM control block.
// Assumes shortened second and recovery counts; host model drives the bus.
`timescale 1ns/1ps
module tb_top;
    import rtc_sram_pkg::*;
    localparam int unsigned SEC = 20;
    localparam int unsigned REC = 10;
    localparam logic [16:0] SEC_ADDR = CLOCK_BASE_ADDR + 17'(IDX_SECONDS);
    typedef struct packed { logic [8:0] lo; logic [8:0] hi; } read_note_s;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        aboveFailThreshold = 1'b1;
    logic        belowSwitchover = 1'b0;
    logic        chipEnable_n, outEnable_n, writeEnable_n, dqOe, onBattery, deselected;
    logic [16:0] addr, base;
    logic [7:0]  dqIn, dqOut;
    logic [7:0]  vals[4];
    read_note_s  notes[$];
    int          failures = 0;
    int          check_count = 0;
    int          n;

    always #12.5 clk = ~clk;

    rtc_sram_ctrl #(.SEC_CYCLES(SEC), .REC_CYCLES(REC)) rtc_sram_ctrl_i (
        .clk(clk), .reset_n(reset_n), .chipEnable_n(chipEnable_n), .outEnable_n(outEnable_n),
        .writeEnable_n(writeEnable_n), .addr(addr), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
        .aboveFailThreshold(aboveFailThreshold), .belowSwitchover(belowSwitchover),
        .onBattery(onBattery), .deselected(deselected));

    host_model host_model_i (
        .clk(clk), .chipEnable_n(chipEnable_n), .outEnable_n(outEnable_n),
        .writeEnable_n(writeEnable_n), .addr(addr), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe));

    task automatic compare_val(input logic [8:0] got, input logic [8:0] lo, input logic [8:0] hi);
        check_count++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            failures++;
            $display("[ERR] t=%0t got=%h expected=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic rd(input logic [16:0] a, input logic oe, input logic [7:0] lo, input logic [7:0] hi);
        notes.push_back('{{oe, lo}, {oe, hi}});
        host_model_i.read_at(a);
    endtask

    task automatic wait_recovery(input logic [8:0] lo);
        n = 0;
        while (deselected !== 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
        compare_val(9'(n), lo, 9'(REC + 2));
    endtask

    task automatic test_done;
        $display("Checks %0d, errors %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin : monitor
        read_note_s note;
        forever begin
            @(host_model_i.readSeen);
            note = notes.pop_front();
            compare_val(host_model_i.seenData, note.lo, note.hi);
        end
    end

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        test_done();
    end

    initial begin
        void'($urandom(32'h1791));
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        wait_recovery(9'(REC - 1));
        base = 17'($urandom_range(0, 32'h0001_F000));
        for (int i = 0; i < 4; i++) begin
            vals[i] = 8'($urandom);
            host_model_i.write_at(base + 17'(i), vals[i]);
        end
        // Power fails in mid-write, then access while deselected
        host_model_i.write_begin(base, ~vals[0]);
        @(negedge clk) aboveFailThreshold = 1'b0;
        host_model_i.write_end();
        compare_val({8'h00, deselected}, 9'h001, 9'h001);
        host_model_i.write_at(base + 17'h1, ~vals[1]);
        rd(base + 17'h2, 1'b0, 8'h00, 8'hFF);
        aboveFailThreshold = 1'b1;
        wait_recovery(9'(REC - 1));
        for (int i = 1; i < 4; i++) begin
            rd(base + 17'(i), 1'b1, vals[i], vals[i]);
        end
        // Time-load halts copies; release loads the counters
        host_model_i.write_at(CLOCK_CONTROL_ADDR, 8'h01 << CTRL_LOAD_BIT);
        host_model_i.write_at(SEC_ADDR, 8'h10);
        repeat (SEC + 4) @(negedge clk);
        rd(SEC_ADDR, 1'b1, 8'h10, 8'h10);
        host_model_i.write_at(CLOCK_CONTROL_ADDR, 8'h00);
        host_model_i.write_at(SEC_ADDR, 8'h55);
        repeat (12) @(negedge clk);
        rd(SEC_ADDR, 1'b1, 8'h55, 8'h55);
        repeat (6) @(negedge clk);
        rd(SEC_ADDR, 1'b1, 8'h10, 8'h11);
        // Freeze before reading, with a battery spell meanwhile
        host_model_i.write_at(CLOCK_CONTROL_ADDR, 8'h01 << CTRL_FREEZE_BIT);
        aboveFailThreshold = 1'b0;
        belowSwitchover = 1'b1;
        repeat (2) @(negedge clk);
        compare_val({8'h00, onBattery}, 9'h001, 9'h001);
        repeat (2 * SEC) @(negedge clk);
        belowSwitchover = 1'b0;
        aboveFailThreshold = 1'b1;
        wait_recovery(9'(REC - 1));
        compare_val({8'h00, onBattery}, 9'h000, 9'h000);
        rd(SEC_ADDR, 1'b1, 8'h10, 8'h11);
        host_model_i.write_at(CLOCK_CONTROL_ADDR, 8'h00);
        repeat (SEC - 6) @(negedge clk);
        rd(SEC_ADDR, 1'b1, 8'h10, 8'h11);
        repeat (6) @(negedge clk);
        rd(SEC_ADDR, 1'b1, 8'h13, 8'h16);
        repeat (2) @(negedge clk);
        test_done();
    end
endmodule
